// ---- include/seg_sched_consts.vh ----
// Register map, field positions and sizes for the segmentation queue scheduler
`ifndef SEG_SCHED_CONSTS_VH
`define SEG_SCHED_CONSTS_VH
`define OFF_SEG_CTRL 8'h20
`define OFF_HRING 8'h40
`define OFF_LRING 8'h44
`define OFF_HSTAT 8'hC0
`define OFF_LSTAT 8'hE0
`define OFF_RING_SIZE 8'h48
`define OFF_BD_COUNT 8'h4C
`define OFF_CPL 8'h50
`define OFF_CPL_ADDR 8'h54
`define OFF_SLOT 8'h58
`define OFF_VCC_CFG 8'h60
`define OFF_VCC_I 8'h64
`define OFF_VCC_L 8'h68
`define OFF_PEEK 8'h6C
`define CTRL_ENABLE 0
`define CTRL_ALT 1
`define CTRL_HS_DIS 2
`define CTRL_LS_DIS 3
`define CTRL_PEND_LSB 4
`define CTRL_MAX_INTERVAL_SIZE_LSB 6
`define ST_RING_OVFL 0
`define ST_DESCRIPTORS_EXHAUSTED 1
`define ST_WRITTEN 2
`define ST_FULL 3
`define ST_RUN 4
`define RING_PTR_W 14
`define BD_COUNT_W 14
`define BD_DEFAULT 14'h0040
`define FRAC_BITS 10
`define NUM_VCC 4
`endif

// ---- rtl/seg_queue_scheduler.v ----
// Segmentation ring front end, status posting and GCRA scheduler
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "seg_sched_consts.vh"

// Behaviour
// - Ring entry is 16 bytes, word aligned
// - New-entry count written at ring register 0x40
// - Processed entry copied to local descriptor
// - Fourteen-bit pending count reported per ring
// - Local ring same, controlled at 0x44
// - Alternation off: local only when host empty
// - Alternation on: rings serviced in turn
// - Overflowing count write discarded, overflow flag set
// - No free descriptor: no service, exhausted flag
// - Per-buffer mode posts each buffer, local/host queue
// - Complete on done, abort or length error
// - Otherwise post only at PDU end, last buffer
// - Status entry: flags, reserved, index, address
// - Owner zero: write entry, set written flag
// - Owner one: overflow, halt, clear enable, run
// - Check disable writes without examining owner
// - Send every I slots, collisions in prior order
// - Late cells shorten intervals, bounded by L
// - Shaping bit: 0 shaped, 1 never scheduled
// - I and L have ten fractional bits
module seg_queue_scheduler (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Wishbone slave
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [7:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	// Ring entry fetch: device reads ring words, copies to descriptor memory
	output reg ring_req_out,
	output reg ring_local_out,
	output reg [13:0] ring_index_out,
	input wire ring_ack_in,
	input wire [31:0] ring_w0_in,
	input wire [31:0] ring_w1_in,
	input wire [31:0] ring_w2_in,
	// Descriptor write to local memory
	output reg bd_wr_out,
	output reg [95:0] bd_data_out,
	// Completion events from the cell builder
	input wire cpl_valid_in,
	input wire cpl_local_in,
	input wire cpl_stm_in,
	input wire cpl_eom_in,
	input wire cpl_length_error_flag_in,
	input wire cpl_stop_in,
	input wire [15:0] cpl_vcc_in,
	input wire [31:0] cpl_addr_in,
	// Status queue access: owner read then entry write, or entry write alone when check is disabled
	output reg sq_rd_out,
	output reg sq_wr_out,
	output reg sq_local_out,
	output reg [63:0] sq_data_out,
	input wire sq_ack_in,
	input wire sq_owner_in,
	// Cell slot tick and scheduled send
	input wire slot_tick_in,
	output reg send_valid_out,
	output reg [15:0] send_vcc_out
);

	localparam S_IDLE = 4'b0001;
	localparam S_FETCH = 4'b0010;
	localparam S_SQRD = 4'b0100;
	localparam S_SQWR = 4'b1000;
	localparam N = `NUM_VCC;

	reg [3:0] state_r;
	reg [31:0] ctrl_r;
	reg [13:0] hsize_r, lsize_r;
	reg [13:0] hpend_r, lpend_r;
	reg [13:0] hhead_r, lhead_r;
	reg [13:0] bd_free_r;
	reg [4:0] hst_r, lst_r;
	reg turn_local_r;
	reg cur_local_r;
	reg [63:0] entry_r;
	reg entry_local_r;
	reg [31:0] slot_r;
	reg [15:0] last_vcc_r;
	reg [31:0] peek_r;
	// Per-connection shaping state
	reg [N-1:0] vcc_ubr_r;
	reg [N-1:0] vcc_act_r;
	reg [23:0] vcc_i_r [0:N-1];
	reg [23:0] vcc_l_r [0:N-1];
	reg [33:0] vcc_tat_r [0:N-1];
	reg [31:0] vcc_seq_r [0:N-1];
	reg [1:0] cfg_sel_r;
	reg [31:0] seq_cnt_r;

	wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	wire wb_wr = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in & wb_sel_in[0]; // Lands at ack
	wire wr_h = wb_wr && wb_adr_in == `OFF_HRING;
	wire wr_l = wb_wr && wb_adr_in == `OFF_LRING;
	wire [13:0] hnew = {6'h00, wb_dat_in[7:0]};
	wire [13:0] lnew = {6'h00, wb_dat_in[7:0]};
	wire h_ovf = wr_h && ({1'b0, hpend_r} + {1'b0, hnew} > {1'b0, hsize_r});
	wire l_ovf = wr_l && ({1'b0, lpend_r} + {1'b0, lnew} > {1'b0, lsize_r});
	wire bd_none = bd_free_r == 14'h0000;
	wire enabled = ctrl_r[`CTRL_ENABLE];
	// Ring choice; a ring is eligible only with pending entries
	wire h_ok = hpend_r != 14'h0000;
	wire l_ok = lpend_r != 14'h0000;
	wire pick_local = ctrl_r[`CTRL_ALT] ? (l_ok & (turn_local_r | ~h_ok)) : ~h_ok;
	wire can_fetch = enabled & ~bd_none & (h_ok | l_ok) & ~cpl_valid_in;
	// Completion qualifies for a status post
	wire post = cpl_valid_in & (cpl_stm_in | cpl_eom_in | cpl_length_error_flag_in);
	wire chk_dis = ((state_r == S_IDLE) ? cpl_local_in : entry_local_r) ?
		ctrl_r[`CTRL_LS_DIS] : ctrl_r[`CTRL_HS_DIS];
	wire fetch_done = state_r == S_FETCH && ring_ack_in;
	wire sq_rd_done = state_r == S_SQRD && sq_ack_in;
	wire sq_full = sq_rd_done & sq_owner_in;
	wire sq_wr_done = state_r == S_SQWR && sq_ack_in;

	// Next ring slot, wrapping at the ring size
	function [13:0] next_idx;
		input [13:0] idx;
		input [13:0] size;
		begin
			next_idx = (idx + 14'h0001 >= size) ? 14'h0000 : idx + 14'h0001;
		end
	endfunction

	// Register read mux
	function [31:0] rd_mux;
		input [7:0] a;
		begin
			case (a)
				`OFF_SEG_CTRL: rd_mux = ctrl_r;
				`OFF_HRING: rd_mux = {2'b00, hpend_r, 16'h0000};
				`OFF_LRING: rd_mux = {2'b00, lpend_r, 16'h0000};
				`OFF_HSTAT: rd_mux = {27'h0, hst_r};
				`OFF_LSTAT: rd_mux = {27'h0, lst_r};
				`OFF_RING_SIZE: rd_mux = {2'b00, lsize_r, 2'b00, hsize_r};
				`OFF_BD_COUNT: rd_mux = {18'h0, bd_free_r};
				`OFF_SLOT: rd_mux = slot_r;
				`OFF_PEEK: rd_mux = peek_r;
				default: rd_mux = 32'h00000000;
			endcase
		end
	endfunction

	// Wishbone answer: one cycle after the strobe, unmapped reads give zero
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_req;
			wb_dat_out <= wb_req ? rd_mux(wb_adr_in) : 32'h00000000;
		end
	end

	// Control and configuration registers
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_r <= 32'h00000000;
			hsize_r <= 14'h0100;
			lsize_r <= 14'h0100;
			cfg_sel_r <= 2'b00;
		end else begin
			if (wb_wr && wb_adr_in == `OFF_SEG_CTRL)
				ctrl_r <= {24'h0, wb_dat_in[7:0]};
			else if (sq_full & ~chk_dis)
				ctrl_r[`CTRL_ENABLE] <= 1'b0;
			if (wb_wr && wb_adr_in == `OFF_RING_SIZE && state_r == S_IDLE) begin
				hsize_r <= wb_dat_in[13:0];
				lsize_r <= wb_dat_in[29:16];
			end
			if (wb_wr && wb_adr_in == `OFF_VCC_CFG)
				cfg_sel_r <= wb_dat_in[1:0];
		end
	end

	// Ring pending counts, heads and descriptor pool
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hpend_r <= 14'h0000;
			lpend_r <= 14'h0000;
			hhead_r <= 14'h0000;
			lhead_r <= 14'h0000;
			bd_free_r <= `BD_DEFAULT;
		end else begin
			// Write adds entries unless it would overrun the ring
			hpend_r <= hpend_r - ((fetch_done & ~cur_local_r) ? 14'h0001 : 14'h0000)
				+ ((wr_h & ~h_ovf) ? hnew : 14'h0000);
			lpend_r <= lpend_r - ((fetch_done & cur_local_r) ? 14'h0001 : 14'h0000)
				+ ((wr_l & ~l_ovf) ? lnew : 14'h0000);
			if (fetch_done & ~cur_local_r)
				hhead_r <= next_idx(hhead_r, hsize_r);
			if (fetch_done & cur_local_r)
				lhead_r <= next_idx(lhead_r, lsize_r);
			if (wb_wr && wb_adr_in == `OFF_BD_COUNT && state_r == S_IDLE)
				bd_free_r <= wb_dat_in[13:0];
			else
				bd_free_r <= bd_free_r - (fetch_done ? 14'h0001 : 14'h0000)
					+ (cpl_valid_in ? 14'h0001 : 14'h0000);
		end
	end

	// Status bits: hardware set wins over a same-cycle write-one clear
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hst_r <= 5'h00;
			lst_r <= 5'h00;
		end else begin
			hst_r[`ST_RING_OVFL] <= h_ovf | (hst_r[`ST_RING_OVFL] &
				~(wb_wr && wb_adr_in == `OFF_HSTAT && wb_dat_in[`ST_RING_OVFL]));
			lst_r[`ST_RING_OVFL] <= l_ovf | (lst_r[`ST_RING_OVFL] &
				~(wb_wr && wb_adr_in == `OFF_LSTAT && wb_dat_in[`ST_RING_OVFL]));
			hst_r[`ST_DESCRIPTORS_EXHAUSTED] <= bd_none;
			lst_r[`ST_DESCRIPTORS_EXHAUSTED] <= bd_none;
			hst_r[`ST_WRITTEN] <= (sq_wr_done & ~entry_local_r) | (hst_r[`ST_WRITTEN] &
				~(wb_wr && wb_adr_in == `OFF_HSTAT && wb_dat_in[`ST_WRITTEN]));
			lst_r[`ST_WRITTEN] <= (sq_wr_done & entry_local_r) | (lst_r[`ST_WRITTEN] &
				~(wb_wr && wb_adr_in == `OFF_LSTAT && wb_dat_in[`ST_WRITTEN]));
			hst_r[`ST_FULL] <= (sq_full & ~chk_dis & ~entry_local_r) | (hst_r[`ST_FULL] &
				~(wb_wr && wb_adr_in == `OFF_HSTAT && wb_dat_in[`ST_FULL]));
			lst_r[`ST_FULL] <= (sq_full & ~chk_dis & entry_local_r) | (lst_r[`ST_FULL] &
				~(wb_wr && wb_adr_in == `OFF_LSTAT && wb_dat_in[`ST_FULL]));
			hst_r[`ST_RUN] <= enabled & ~(sq_full & ~chk_dis);
			lst_r[`ST_RUN] <= enabled & ~(sq_full & ~chk_dis);
		end
	end

	// Main sequencer: ring fetch and status posting; completions take priority
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= S_IDLE;
			ring_req_out <= 1'b0;
			ring_local_out <= 1'b0;
			ring_index_out <= 14'h0000;
			bd_wr_out <= 1'b0;
			bd_data_out <= 96'h0;
			sq_rd_out <= 1'b0;
			sq_wr_out <= 1'b0;
			sq_local_out <= 1'b0;
			sq_data_out <= 64'h0;
			cur_local_r <= 1'b0;
			turn_local_r <= 1'b0;
			entry_r <= 64'h0;
			entry_local_r <= 1'b0;
			last_vcc_r <= 16'h0000;
		end else begin
			bd_wr_out <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (post) begin
						// Flags, 11 reserved bits, index, then buffer address
						entry_r <= {1'b1, cpl_length_error_flag_in, cpl_stop_in, 1'b1, cpl_eom_in,
							11'h000, cpl_vcc_in, cpl_addr_in};
						entry_local_r <= cpl_local_in;
						sq_local_out <= cpl_local_in;
						if (chk_dis) begin
							sq_wr_out <= 1'b1;
							sq_data_out <= {1'b1, cpl_length_error_flag_in, cpl_stop_in, 1'b1,
								cpl_eom_in, 11'h000, cpl_vcc_in, cpl_addr_in};
							state_r <= S_SQWR;
						end else begin
							sq_rd_out <= 1'b1;
							state_r <= S_SQRD;
						end
					end else if (can_fetch) begin
						cur_local_r <= pick_local;
						ring_local_out <= pick_local;
						ring_index_out <= pick_local ? lhead_r : hhead_r;
						ring_req_out <= 1'b1;
						turn_local_r <= ~pick_local;
						state_r <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (ring_ack_in) begin
						ring_req_out <= 1'b0;
						// Word three of the entry is never read
						bd_data_out <= {ring_w0_in, ring_w1_in, ring_w2_in};
						bd_wr_out <= 1'b1;
						last_vcc_r <= ring_w1_in[15:0];
						state_r <= S_IDLE;
					end
				end
				S_SQRD: begin
					if (sq_ack_in) begin
						sq_rd_out <= 1'b0;
						if (sq_owner_in)
							state_r <= S_IDLE;
						else begin
							sq_wr_out <= 1'b1;
							sq_data_out <= entry_r;
							state_r <= S_SQWR;
						end
					end
				end
				S_SQWR: begin
					if (sq_ack_in) begin
						sq_wr_out <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Peek register shows sequencer state and last linked connection
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			peek_r <= 32'h00000000;
		else
			peek_r <= {12'h000, state_r, last_vcc_r};
	end

	// Shaping table: I and L fixed point with ten fractional bits
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vcc_ubr_r <= {N{1'b0}};
			vcc_act_r <= {N{1'b0}};
		end else if (wb_wr && wb_adr_in == `OFF_VCC_CFG) begin
			vcc_act_r[wb_dat_in[1:0]] <= wb_dat_in[8];
			vcc_ubr_r[wb_dat_in[1:0]] <= wb_dat_in[9];
		end
	end

	// Slot scheduler: eligible shaped connection sent least recently, ties to the lowest index
	reg [33:0] now_fx;
	reg found;
	reg [1:0] win;
	integer k;
	always @* begin
		now_fx = {slot_r[23:0], 10'h000};
		found = 1'b0;
		win = 2'b00;
		for (k = 0; k < N; k = k + 1) begin
			if (vcc_act_r[k] && !vcc_ubr_r[k] && vcc_tat_r[k] <= now_fx + {10'h0, vcc_l_r[k]}) begin
				if (!found || vcc_seq_r[k] < vcc_seq_r[win]) begin
					found = 1'b1;
					win = k[1:0];
				end
			end
		end
	end

	// Theoretical arrival time update keeps mean interval I, burst bounded by L
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_vcc
			always @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					vcc_i_r[g] <= 24'h000400;
					vcc_l_r[g] <= 24'h000000;
					vcc_tat_r[g] <= 34'h0;
					vcc_seq_r[g] <= 32'h0;
				end else begin
					if (wb_wr && wb_adr_in == `OFF_VCC_I && cfg_sel_r == g)
						vcc_i_r[g] <= wb_dat_in[23:0];
					if (wb_wr && wb_adr_in == `OFF_VCC_L && cfg_sel_r == g)
						vcc_l_r[g] <= wb_dat_in[23:0];
					if (slot_tick_in && found && win == g) begin
						// Late cell: restart from now rather than the old TAT, so future gaps shrink by at most L
						vcc_tat_r[g] <= ((vcc_tat_r[g] > now_fx) ? vcc_tat_r[g] : now_fx)
							+ {10'h0, vcc_i_r[g]};
						vcc_seq_r[g] <= seq_cnt_r;
					end
				end
			end
		end
	endgenerate

	// Slot counter and send output
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			slot_r <= 32'h0;
			seq_cnt_r <= 32'h1;
			send_valid_out <= 1'b0;
			send_vcc_out <= 16'h0000;
		end else begin
			send_valid_out <= slot_tick_in & found & enabled;
			if (slot_tick_in) begin
				slot_r <= slot_r + 32'h1;
				if (found) begin
					seq_cnt_r <= seq_cnt_r + 32'h1;
					send_vcc_out <= {14'h0, win};
				end
			end
		end
	end

endmodule // seg_queue_scheduler

// ---- tb/seg_queue_scheduler_monitor.sv ----
// Port-level assertions for the segmentation queue scheduler
`timescale 1ns/1ps
module seg_queue_scheduler_monitor (
	// Clock, reset and register bus
	input wire clk_in, rstn_in, wb_cyc_in, wb_stb_in, wb_ack_out,
	input wire [31:0] wb_dat_out,
	// Ring fetch and descriptor copy
	input wire ring_req_out, ring_local_out, ring_ack_in, bd_wr_out,
	input wire [13:0] ring_index_out,
	input wire [31:0] ring_w0_in, ring_w1_in, ring_w2_in,
	input wire [95:0] bd_data_out,
	// Status queue and scheduler
	input wire sq_rd_out, sq_wr_out, sq_ack_in, sq_owner_in, slot_tick_in, send_valid_out,
	input wire [63:0] sq_data_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Register access answers after one cycle and for one cycle only
	a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("register access not answered");
	a_ack_once: assert property (wb_ack_out |=> !wb_ack_out && wb_dat_out == 32'h0)
		else $error("acknowledge held or read data left on bus");
	// A fetch request stays put until answered, then its words land in the descriptor
	a_fetch_hold: assert property (ring_req_out && !ring_ack_in |=>
		ring_req_out && $stable(ring_index_out) && $stable(ring_local_out))
		else $error("fetch request changed before answer");
	a_copy_words: assert property (ring_req_out && ring_ack_in |=> bd_wr_out &&
		bd_data_out == {$past(ring_w0_in), $past(ring_w1_in), $past(ring_w2_in)})
		else $error("descriptor differs from ring entry");
	a_copy_cause: assert property (bd_wr_out |-> $past(ring_ack_in) && !ring_req_out)
		else $error("descriptor write without fetched entry");
	// Status slot already owned: no write in the four cycles that follow
	a_owner_stop: assert property (sq_rd_out && sq_ack_in && sq_owner_in |=> !sq_wr_out [*4])
		else $error("status written over owned slot");
	a_entry_owned: assert property (sq_wr_out |->
		sq_data_out[63] && sq_data_out[60] && sq_data_out[58:48] == 11'h000)
		else $error("status entry owner or reserved bits wrong");
	a_rd_wr_excl: assert property (!(sq_rd_out && sq_wr_out))
		else $error("owner read and entry write together");
	a_send_tick: assert property (send_valid_out |-> $past(slot_tick_in))
		else $error("cell sent without a slot");
endmodule // seg_queue_scheduler_monitor

// ---- tb/ring_mem_model.sv ----
// Far-side memory model: transmit ring entries and status queue slots
`timescale 1ns/1ps
module ring_mem_model (
	input wire clk_in, rstn_in,
	// Ring entry fetch
	input wire ring_req_in, ring_local_in,
	input wire [13:0] ring_index_in,
	output reg ring_ack_out,
	output reg [31:0] ring_w0_out, ring_w1_out, ring_w2_out,
	// Status queue; delay_in sets answer latency, owner_in the owner bit found
	input wire sq_rd_in, sq_wr_in, owner_in,
	input wire [1:0] delay_in,
	output reg sq_ack_out, sq_owner_out
);
	integer rwait, swait;
	// Ring slots: three written words per 16-byte slot, fourth word never offered
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ring_ack_out <= 1'b0;
			rwait <= 0;
			{ring_w0_out, ring_w1_out, ring_w2_out} <= 96'h0;
		end else if (ring_ack_out) begin
			ring_ack_out <= 1'b0;
			// Released lines must not keep showing the entry
			{ring_w0_out, ring_w1_out, ring_w2_out} <= ~{ring_w0_out, ring_w1_out, ring_w2_out};
		end else if (ring_req_in && rwait < delay_in) begin
			rwait <= rwait + 1;
		end else if (ring_req_in) begin
			rwait <= 0;
			ring_ack_out <= 1'b1;
			ring_w0_out <= {4'hA, 13'h0000, ring_local_in, ring_index_in};
			ring_w1_out <= {2'h0, ring_index_in, 16'h0003};
			ring_w2_out <= {1'b0, ring_local_in, 30'h00000040};
		end
	end
	// Status slots: owner bit is clear unless software still holds the slot
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sq_ack_out <= 1'b0;
			sq_owner_out <= 1'b0;
			swait <= 0;
		end else if (sq_ack_out) begin
			sq_ack_out <= 1'b0;
			sq_owner_out <= ~sq_owner_out;
		end else if ((sq_rd_in || sq_wr_in) && swait < delay_in) begin
			swait <= swait + 1;
		end else if (sq_rd_in || sq_wr_in) begin
			swait <= 0;
			sq_ack_out <= 1'b1;
			sq_owner_out <= sq_rd_in & owner_in;
		end
	end
endmodule // ring_mem_model

// ---- tb/segmentation_queue_scheduler_tb.sv ----
// Self-checking bench for the segmentation queue scheduler
`timescale 1ns/1ps
`include "seg_sched_consts.vh"
module segmentation_queue_scheduler_tb;
	// Design inputs, defined from time zero
	reg clk_in = 1'b0, rstn_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
	reg [7:0] wb_adr_in = 8'h00;
	reg [3:0] wb_sel_in = 4'hF;
	reg [31:0] wb_dat_in = 32'h0, cpl_addr_in = 32'h0, rd, rng = 32'h0000002D;
	reg cpl_valid_in = 1'b0, cpl_local_in = 1'b0, cpl_stm_in = 1'b0, cpl_eom_in = 1'b0;
	reg cpl_length_error_flag_in = 1'b0, cpl_stop_in = 1'b0, slot_tick_in = 1'b0, owner = 1'b0, sql;
	reg [15:0] cpl_vcc_in = 16'h0;
	reg [1:0] delay = 2'h0;
	reg [95:0] cw;
	reg [63:0] sqd;
	// Design outputs and partner answers
	wire [31:0] wb_dat_out, ring_w0_in, ring_w1_in, ring_w2_in;
	wire wb_ack_out, ring_req_out, ring_local_out, ring_ack_in, bd_wr_out, sq_rd_out;
	wire sq_wr_out, sq_local_out, sq_ack_in, sq_owner_in, send_valid_out;
	wire [13:0] ring_index_out;
	wire [95:0] bd_data_out;
	wire [63:0] sq_data_out;
	wire [15:0] send_vcc_out;
	integer n_errors = 0, check_count = 0, hp = 0, lp = 0, hidx = 0, lidx = 0, nfetch = 0;
	integer alt = 0, last_loc = -1, nsq = 0, nrd = 0, ticks = 0, nsend = 0, lastsend = 0, k;
	seg_queue_scheduler i_dut (.clk_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
		.wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .ring_req_out, .ring_local_out,
		.ring_index_out, .ring_ack_in, .ring_w0_in, .ring_w1_in, .ring_w2_in, .bd_wr_out,
		.bd_data_out, .cpl_valid_in, .cpl_local_in, .cpl_stm_in, .cpl_eom_in, .cpl_length_error_flag_in,
		.cpl_stop_in, .cpl_vcc_in, .cpl_addr_in, .sq_rd_out, .sq_wr_out, .sq_local_out,
		.sq_data_out, .sq_ack_in, .sq_owner_in, .slot_tick_in, .send_valid_out, .send_vcc_out);
	ring_mem_model i_mem (.clk_in, .rstn_in, .ring_req_in(ring_req_out),
		.ring_local_in(ring_local_out), .ring_index_in(ring_index_out), .ring_ack_out(ring_ack_in),
		.ring_w0_out(ring_w0_in), .ring_w1_out(ring_w1_in), .ring_w2_out(ring_w2_in),
		.sq_rd_in(sq_rd_out), .sq_wr_in(sq_wr_out), .owner_in(owner), .delay_in(delay),
		.sq_ack_out(sq_ack_in), .sq_owner_out(sq_owner_in));
	always #2 clk_in = ~clk_in;
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	task chk(input [95:0] got, input [95:0] exp, input [8*12:1] nm);
		check_count = check_count + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Classic single cycle: request held until ack is sampled, then released
	task wb(input we, input [7:0] a, input [31:0] d);
		@(posedge clk_in);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, we, a, d};
		do @(posedge clk_in); while (wb_ack_out !== 1'b1);
		rd = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'h0;
	endtask
	task rdchk(input [7:0] a, input [31:0] m, input [31:0] e, input [8*12:1] nm);
		wb(1'b0, a, 32'h0);
		chk(rd & m, e, nm);
	endtask
	task waitfetch(input integer n);
		while (nfetch < n) @(posedge clk_in);
		chk(nfetch, n, "fetches");
	endtask
	// Slot ticks, one every second cycle
	task tick(input integer n);
		repeat (n) begin
			@(posedge clk_in);
			slot_tick_in <= 1'b1;
			@(posedge clk_in);
			slot_tick_in <= 1'b0;
		end
	endtask
	// One completion in an idle cycle; expw says whether an entry must appear
	task post(input loc, input stm, input eom, input le, input integer expw);
		integer n0, n;
		reg [15:0] v;
		reg [31:0] ad;
		n0 = nsq;
		v = 16'(xs());
		ad = xs();
		@(posedge clk_in);
		{cpl_valid_in, cpl_local_in, cpl_stm_in, cpl_eom_in} <= {1'b1, loc, stm, eom};
		{cpl_length_error_flag_in, cpl_stop_in, cpl_vcc_in, cpl_addr_in} <= {le, ad[7], v, ad};
		@(posedge clk_in);
		cpl_valid_in <= 1'b0;
		for (n = 0; n < 40 && nsq == n0; n = n + 1) @(posedge clk_in);
		chk(nsq - n0, expw, "entries");
		if (expw == 1) chk({sqd[63:59], sqd[47:0], sql},
			{1'b1, le, ad[7], 1'b1, eom, v, ad, loc}, "entry");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Reference model: ring order, slot index, copies, status entries and sends
	always @(posedge clk_in) begin
		delay <= 2'(xs());
		if (ring_req_out === 1'b1 && ring_ack_in === 1'b1) begin
			cw = {ring_w0_in, ring_w1_in, ring_w2_in};
			if (alt && hp > 0 && lp > 0) chk(ring_local_out == last_loc, 0, "alternate");
			if (!alt && hp > 0) chk(ring_local_out, 0, "host first");
			chk(ring_index_out, ring_local_out ? lidx : hidx, "slot");
			last_loc = ring_local_out;
			if (ring_local_out) {lidx, lp} = {(lidx + 1) % 256, lp - 1};
			else {hidx, hp} = {(hidx + 1) % 256, hp - 1};
		end
		if (bd_wr_out === 1'b1) nfetch = nfetch + 1;
		if (bd_wr_out === 1'b1) chk(bd_data_out, cw, "descriptor");
		if (sq_rd_out === 1'b1 && sq_ack_in === 1'b1) nrd = nrd + 1;
		if (sq_wr_out === 1'b1 && sq_ack_in === 1'b1) {nsq, sqd, sql} = {nsq + 1, sq_data_out, sq_local_out};
		if (slot_tick_in) ticks = ticks + 1;
		if (send_valid_out === 1'b1) begin
			chk(send_vcc_out, 0, "send vcc");
			chk(nsend > 0 && ticks - lastsend < 4, 0, "gap");
			{nsend, lastsend} = {nsend + 1, ticks};
		end
	end
	// Watchdog, far beyond the few thousand nanoseconds the tests need
	initial begin
		#160000;
		n_errors = n_errors + 1;
		close_out;
	end
	initial begin
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		rdchk(`OFF_RING_SIZE, 32'hFFFFFFFF, 32'h01000100, "ring size");
		rdchk(`OFF_BD_COUNT, 32'h3FFF, 32'h40, "free count");
		rdchk(8'h7C, 32'hFFFFFFFF, 32'h0, "unmapped");
		$display("test registers done");
		wb(1'b1, `OFF_HRING, 32'h03);
		wb(1'b1, `OFF_LRING, 32'h02);
		{hp, lp} = {32'd3, 32'd2};
		rdchk(`OFF_HRING, 32'h3FFF0000, 32'h00030000, "host pend");
		rdchk(`OFF_LRING, 32'h3FFF0000, 32'h00020000, "local pend");
		wb(1'b1, `OFF_SEG_CTRL, 32'h01);
		waitfetch(5);
		rdchk(`OFF_HRING, 32'h3FFF0000, 32'h0, "host empty");
		$display("test ring order done");
		post(1'b0, 1'b1, 1'b0, 1'b0, 1);
		rdchk(`OFF_HSTAT, 32'h4, 32'h4, "host wr");
		post(1'b1, 1'b1, 1'b0, 1'b0, 1);
		rdchk(`OFF_LSTAT, 32'h4, 32'h4, "local wr");
		post(1'b1, 1'b0, 1'b0, 1'b0, 0);
		post(1'b0, 1'b0, 1'b1, 1'b0, 1);
		post(1'b0, 1'b0, 1'b0, 1'b1, 1);
		owner <= 1'b1;
		post(1'b0, 1'b1, 1'b0, 1'b0, 0);
		rdchk(`OFF_HSTAT, 32'h18, 32'h08, "halted");
		rdchk(`OFF_SEG_CTRL, 32'h1, 32'h0, "enable off");
		wb(1'b1, `OFF_HSTAT, 32'h08);
		wb(1'b1, `OFF_SEG_CTRL, 32'h01);
		rdchk(`OFF_HSTAT, 32'h18, 32'h10, "restarted");
		wb(1'b1, `OFF_SEG_CTRL, 32'h05);
		k = nrd;
		post(1'b0, 1'b1, 1'b0, 1'b0, 1);
		chk(nrd - k, 0, "owner reads");
		owner <= 1'b0;
		wb(1'b1, `OFF_SEG_CTRL, 32'h01);
		$display("test status done");
		wb(1'b1, `OFF_VCC_CFG, 32'h100);
		wb(1'b1, `OFF_VCC_I, 32'h1000);
		wb(1'b1, `OFF_VCC_L, 32'h0);
		tick(80);
		wb(1'b1, `OFF_VCC_CFG, 32'h300);
		chk(nsend >= 19 && nsend <= 21, 1, "sends");
		k = nsend;
		tick(12);
		wb(1'b1, `OFF_VCC_CFG, 32'h0);
		chk(nsend - k, 0, "ubr unshaped");
		$display("test scheduler done");
		wb(1'b1, `OFF_SEG_CTRL, 32'h0);
		wb(1'b1, `OFF_HRING, 32'hC8);
		wb(1'b1, `OFF_HRING, 32'h64);
		wb(1'b1, `OFF_LRING, 32'h0A);
		wb(1'b1, `OFF_LRING, 32'hFA);
		{hp, lp, alt, last_loc} = {32'd200, 32'd10, 32'd1, -32'sd1};
		rdchk(`OFF_HRING, 32'h3FFF0000, 32'h00C80000, "host kept");
		rdchk(`OFF_HSTAT, 32'h1, 32'h1, "host ovfl");
		rdchk(`OFF_LSTAT, 32'h1, 32'h1, "local ovfl");
		wb(1'b1, `OFF_SEG_CTRL, 32'h03);
		k = -1;
		while (k != nfetch) begin
			k = nfetch;
			repeat (60) @(posedge clk_in);
		end
		chk(ring_req_out, 0, "stalled");
		rdchk(`OFF_HSTAT, 32'h2, 32'h2, "host bd");
		rdchk(`OFF_LSTAT, 32'h2, 32'h2, "local bd");
		post(1'b0, 1'b0, 1'b0, 1'b0, 0);
		waitfetch(k + 1);
		$display("test overflow and exhaustion done");
		close_out;
	end
endmodule // segmentation_queue_scheduler_tb
bind seg_queue_scheduler seg_queue_scheduler_monitor i_mon (.clk_in, .rstn_in, .wb_cyc_in,
	.wb_stb_in, .wb_ack_out, .wb_dat_out, .ring_req_out, .ring_local_out, .ring_ack_in, .bd_wr_out,
	.ring_index_out, .ring_w0_in, .ring_w1_in, .ring_w2_in, .bd_data_out, .sq_rd_out, .sq_wr_out,
	.sq_ack_in, .sq_owner_in, .slot_tick_in, .send_valid_out, .sq_data_out);
